/* core/fsp_frame_sync_pins.sv */
/*
  Function logic of the receive and transmit frame sync pins of one
  serial audio port, with its APB register slave.
  Assumes the transmitter and receiver cores run on pclk and the pins
  and bit clock come from outside and are synchronised here.
*/
// How it works
// RL1: Asynchronous mode: receive pin is the receivers' frame sync in or out.
// RL2: Synchronous mode, buffer select clear: receive pin is serial flag one.
// RL3: Synchronous, buffer select and rx direction set: drive buffer enable.
// RL4: As a flag, receive pin direction follows rx frame sync direction.
// RL5: Output flag drives pin, updated on frame sync or slot.
// RL6: Input flag captures pin on frame sync or slot.
// RL7: Synchronous mode: transmit pin is common frame sync for all.
// RL8: Asynchronous mode: transmit pin serves transmitters only.
// RL9: Transmit pin direction follows tx frame sync direction bit.
// RL10: In GPIO use each pin is input, output or disconnected.
// RL11: Reset leaves both pins GPIO and disconnected.
// RL12: A GPIO pin neither drives nor samples frame sync.
`include "fsp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module fsp_frame_sync_pins (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame_sync_pin_in,
  output logic rx_frame_sync_pin_out,
  output logic rx_frame_sync_pin_oe_n,
  input wire logic tx_frame_sync_pin_in,
  output logic tx_frame_sync_pin_out,
  output logic tx_frame_sync_pin_oe_n,
  input wire logic sck_pin,
  input wire logic rx_fs_gen,
  input wire logic tx_fs_gen,
  input wire logic tx_buf_en,
  input wire logic slot_start,
  output logic rx_fs,
  output logic tx_fs,
  output logic input_flag_one
);

  fsp_sync_if sif ();

  logic rx_fs_direction;
  logic tx_fs_direction;
  logic sync_mode_select;
  logic tx_buffer_enable_select;
  logic output_flag_one;
  logic network_mode;
  logic rx_audio;
  logic tx_audio;
  logic [1:0] rx_gmode;
  logic [1:0] tx_gmode;
  logic rx_gout;
  logic tx_gout;
  logic flag_drive;
  logic rx_fs_smp;
  logic tx_fs_smp;
  logic sck_prev;
  logic sck_rise;
  logic rx_level;
  logic tx_level;
  logic fs_rise;
  logic flag_upd;
  logic next_rx_out;
  logic next_tx_out;
  logic wr;
  logic hit;
  logic [31:0] next_prdata;
  fsp_pkg::fsp_role_t rx_role;
  fsp_pkg::fsp_role_t tx_role;

  // ****************************************
  // Role decoding
  // ****************************************
  function automatic fsp_pkg::fsp_role_t pin_role(
    input logic aud,
    input logic [1:0] mode,
    input fsp_pkg::fsp_role_t audio_role
  );
    fsp_pkg::fsp_role_t r;
    r = fsp_pkg::ROLE_GPIO_OFF;
    if (aud)
      r = audio_role;
    else if (mode == fsp_pkg::GMODE_IN)
      r = fsp_pkg::ROLE_GPIO_IN;
    else if (mode == fsp_pkg::GMODE_OUT)
      r = fsp_pkg::ROLE_GPIO_OUT;
    return r;
  endfunction

  function automatic logic role_drives(input fsp_pkg::fsp_role_t r);
    return r == fsp_pkg::ROLE_GPIO_OUT || r == fsp_pkg::ROLE_FS_OUT ||
      r == fsp_pkg::ROLE_FLAG_OUT || r == fsp_pkg::ROLE_BUF_EN;
  endfunction

  always_comb
  begin
    if (!sync_mode_select)
      rx_role = pin_role(rx_audio, rx_gmode, rx_fs_direction ?
        fsp_pkg::ROLE_FS_OUT : fsp_pkg::ROLE_FS_IN); // RL1
    else if (tx_buffer_enable_select && rx_fs_direction)
      rx_role = pin_role(rx_audio, rx_gmode,
        fsp_pkg::ROLE_BUF_EN); // RL3
    else
      rx_role = pin_role(rx_audio, rx_gmode, rx_fs_direction ?
        fsp_pkg::ROLE_FLAG_OUT : fsp_pkg::ROLE_FLAG_IN); // RL2 RL4
    tx_role = pin_role(tx_audio, tx_gmode, tx_fs_direction ?
      fsp_pkg::ROLE_FS_OUT : fsp_pkg::ROLE_FS_IN); // RL9 RL10
  end

  // ****************************************
  // Input sampling
  // ****************************************
  assign sif.raw = {sck_pin, tx_frame_sync_pin_in, rx_frame_sync_pin_in};

  fsp_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .s(sif.sync_side)
  );

  assign sck_rise = sif.sync[2] && !sck_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_prev <= `FSP_RST_BIT;
    else
      sck_prev <= sif.sync[2];
  end

  // Frame sync inputs update at rising bit clock edges and clear outside the input role
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_fs_smp <= `FSP_RST_BIT;
      tx_fs_smp <= `FSP_RST_BIT;
    end
    else
    begin
      if (rx_role != fsp_pkg::ROLE_FS_IN)
        rx_fs_smp <= 1'b0; // RL12
      else if (sck_rise)
        rx_fs_smp <= sif.sync[0];
      if (tx_role != fsp_pkg::ROLE_FS_IN)
        tx_fs_smp <= 1'b0; // RL12
      else if (sck_rise)
        tx_fs_smp <= sif.sync[1];
    end
  end

  // ****************************************
  // Frame sync routing
  // ****************************************
  always_comb
  begin
    tx_level = 1'b0;
    if (tx_role == fsp_pkg::ROLE_FS_OUT)
      tx_level = tx_fs_gen;
    else if (tx_role == fsp_pkg::ROLE_FS_IN)
      tx_level = tx_fs_smp;
    rx_level = 1'b0;
    if (sync_mode_select)
      rx_level = tx_level; // RL7
    else if (rx_role == fsp_pkg::ROLE_FS_OUT)
      rx_level = rx_fs_gen; // RL8
    else if (rx_role == fsp_pkg::ROLE_FS_IN)
      rx_level = rx_fs_smp; // RL8
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_fs <= `FSP_RST_BIT;
      tx_fs <= `FSP_RST_BIT;
    end
    else
    begin
      rx_fs <= rx_level;
      tx_fs <= tx_level;
    end
  end

  // ****************************************
  // Serial flag one
  // ****************************************
  assign fs_rise = rx_level && !rx_fs;
  assign flag_upd = network_mode ? slot_start : fs_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_drive <= `FSP_RST_BIT;
    else if (flag_upd)
      flag_drive <= output_flag_one; // RL5
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      input_flag_one <= `FSP_RST_BIT;
    else if (flag_upd && rx_role == fsp_pkg::ROLE_FLAG_IN)
      input_flag_one <= sif.sync[0]; // RL6
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_comb
  begin
    case (rx_role)
      fsp_pkg::ROLE_GPIO_OUT: next_rx_out = rx_gout;
      fsp_pkg::ROLE_FS_OUT: next_rx_out = rx_fs_gen;
      fsp_pkg::ROLE_FLAG_OUT: next_rx_out = flag_drive;
      fsp_pkg::ROLE_BUF_EN: next_rx_out = tx_buf_en;
      default: next_rx_out = 1'b0;
    endcase
    case (tx_role)
      fsp_pkg::ROLE_GPIO_OUT: next_tx_out = tx_gout;
      fsp_pkg::ROLE_FS_OUT: next_tx_out = tx_fs_gen;
      default: next_tx_out = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_frame_sync_pin_out <= `FSP_RST_BIT;
      tx_frame_sync_pin_out <= `FSP_RST_BIT;
      rx_frame_sync_pin_oe_n <= `FSP_RST_OE_N; // RL11
      tx_frame_sync_pin_oe_n <= `FSP_RST_OE_N; // RL11
    end
    else
    begin
      rx_frame_sync_pin_out <= next_rx_out; // RL1 RL3 RL5
      tx_frame_sync_pin_out <= next_tx_out; // RL9
      rx_frame_sync_pin_oe_n <= !role_drives(rx_role); // RL4 RL10
      tx_frame_sync_pin_oe_n <= !role_drives(tx_role); // RL9 RL10
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign hit = paddr == `FSP_OFS_RX_CLK_CTRL ||
    paddr == `FSP_OFS_TX_CLK_CTRL || paddr == `FSP_OFS_COMMON_CTRL ||
    paddr == `FSP_OFS_COMMON_STATUS || paddr == `FSP_OFS_GPIO_CTRL;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_fs_direction <= `FSP_RST_BIT;
      tx_fs_direction <= `FSP_RST_BIT;
      sync_mode_select <= `FSP_RST_BIT;
      tx_buffer_enable_select <= `FSP_RST_BIT;
      output_flag_one <= `FSP_RST_BIT;
      network_mode <= `FSP_RST_BIT;
      rx_audio <= `FSP_RST_BIT; // RL11
      tx_audio <= `FSP_RST_BIT; // RL11
      rx_gmode <= `FSP_RST_MODE; // RL11
      tx_gmode <= `FSP_RST_MODE; // RL11
      rx_gout <= `FSP_RST_BIT;
      tx_gout <= `FSP_RST_BIT;
    end
    else if (wr)
    begin
      if (paddr == `FSP_OFS_RX_CLK_CTRL)
        rx_fs_direction <= pwdata[`FSP_BIT_RX_FS_DIR];
      else if (paddr == `FSP_OFS_TX_CLK_CTRL)
        tx_fs_direction <= pwdata[`FSP_BIT_TX_FS_DIR];
      else if (paddr == `FSP_OFS_COMMON_CTRL)
      begin
        sync_mode_select <= pwdata[`FSP_BIT_SYNC_MODE];
        tx_buffer_enable_select <= pwdata[`FSP_BIT_TX_BUF_SEL];
        output_flag_one <= pwdata[`FSP_BIT_OUT_FLAG];
        network_mode <= pwdata[`FSP_BIT_NETWORK];
      end
      else if (paddr == `FSP_OFS_GPIO_CTRL)
      begin
        rx_audio <= pwdata[`FSP_BIT_RX_AUDIO];
        rx_gmode <= pwdata[`FSP_BIT_RX_MODE +: 2];
        rx_gout <= pwdata[`FSP_BIT_RX_GOUT];
        tx_audio <= pwdata[`FSP_BIT_TX_AUDIO];
        tx_gmode <= pwdata[`FSP_BIT_TX_MODE +: 2];
        tx_gout <= pwdata[`FSP_BIT_TX_GOUT];
      end
    end
  end

  // Read data is staged in the setup cycle
  always_comb
  begin
    next_prdata = 32'h00000000;
    if (paddr == `FSP_OFS_RX_CLK_CTRL)
      next_prdata[`FSP_BIT_RX_FS_DIR] = rx_fs_direction;
    else if (paddr == `FSP_OFS_TX_CLK_CTRL)
      next_prdata[`FSP_BIT_TX_FS_DIR] = tx_fs_direction;
    else if (paddr == `FSP_OFS_COMMON_CTRL)
    begin
      next_prdata[`FSP_BIT_SYNC_MODE] = sync_mode_select;
      next_prdata[`FSP_BIT_TX_BUF_SEL] = tx_buffer_enable_select;
      next_prdata[`FSP_BIT_OUT_FLAG] = output_flag_one;
      next_prdata[`FSP_BIT_NETWORK] = network_mode;
    end
    else if (paddr == `FSP_OFS_COMMON_STATUS)
    begin
      next_prdata[`FSP_BIT_IN_FLAG] = input_flag_one;
      next_prdata[`FSP_BIT_RX_LEVEL] =
        rx_role == fsp_pkg::ROLE_GPIO_IN && sif.sync[0];
      next_prdata[`FSP_BIT_TX_LEVEL] =
        tx_role == fsp_pkg::ROLE_GPIO_IN && sif.sync[1];
      next_prdata[`FSP_BIT_FS_LEVEL] = rx_fs;
    end
    else if (paddr == `FSP_OFS_GPIO_CTRL)
    begin
      next_prdata[`FSP_BIT_RX_AUDIO] = rx_audio;
      next_prdata[`FSP_BIT_RX_MODE +: 2] = rx_gmode;
      next_prdata[`FSP_BIT_RX_GOUT] = rx_gout;
      next_prdata[`FSP_BIT_TX_AUDIO] = tx_audio;
      next_prdata[`FSP_BIT_TX_MODE +: 2] = tx_gmode;
      next_prdata[`FSP_BIT_TX_GOUT] = tx_gout;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= next_prdata;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_rx_async_fs: assert property (
    rx_audio && !sync_mode_select && rx_fs_direction |=>
      !rx_frame_sync_pin_oe_n && rx_frame_sync_pin_out == $past(rx_fs_gen)
  ) else $error("rx pin not driving receiver frame sync"); // RL1
  a_rx_flag_out: assert property (
    rx_audio && sync_mode_select && !tx_buffer_enable_select &&
      rx_fs_direction |=>
      !rx_frame_sync_pin_oe_n && rx_frame_sync_pin_out == $past(flag_drive)
  ) else $error("rx pin not driving output flag"); // RL2
  a_rx_buf_en: assert property (
    rx_audio && sync_mode_select && tx_buffer_enable_select &&
      rx_fs_direction |=> rx_frame_sync_pin_out == $past(tx_buf_en)
  ) else $error("rx pin not driving buffer enable"); // RL3
  a_flag_in_dir: assert property (
    rx_audio && sync_mode_select && !rx_fs_direction |=>
      rx_frame_sync_pin_oe_n
  ) else $error("input flag pin driven"); // RL4
  a_flag_update: assert property (
    flag_upd |=> flag_drive == $past(output_flag_one)
  ) else $error("output flag not updated at sync"); // RL5
  a_flag_hold: assert property (
    !flag_upd |=> $stable(flag_drive)
  ) else $error("output flag changed between syncs"); // RL5
  a_flag_capture: assert property (
    flag_upd && rx_role == fsp_pkg::ROLE_FLAG_IN |=>
      input_flag_one == $past(sif.sync[0])
  ) else $error("input flag not captured"); // RL6
  a_common_fs: assert property (
    sync_mode_select ##1 sync_mode_select |-> rx_fs == tx_fs
  ) else $error("receivers not on common frame sync"); // RL7
  a_async_rx_own: assert property (
    !sync_mode_select && rx_role == fsp_pkg::ROLE_FS_OUT |=>
      rx_fs == $past(rx_fs_gen)
  ) else $error("receivers not on own frame sync"); // RL8
  a_tx_dir: assert property (
    tx_audio |=> tx_frame_sync_pin_oe_n == !$past(tx_fs_direction)
  ) else $error("tx pin direction wrong"); // RL9
  a_gpio_off: assert property (
    !rx_audio && rx_gmode == fsp_pkg::GMODE_OFF |=> rx_frame_sync_pin_oe_n
  ) else $error("disconnected pin driven"); // RL10 RL11
  a_gpio_ignore: assert property (
    !rx_audio && !sync_mode_select |=> !rx_fs
  ) else $error("gpio pin used as frame sync"); // RL12

  c_async_fs_in: cover property (
    rx_role == fsp_pkg::ROLE_FS_IN && fs_rise);
  c_flag_in: cover property (
    rx_role == fsp_pkg::ROLE_FLAG_IN && flag_upd);
  c_buf_en: cover property (rx_role == fsp_pkg::ROLE_BUF_EN);
  c_network: cover property (network_mode && slot_start);

endmodule
`default_nettype wire

/* core/fsp_defs.svh */
/*
  Offsets, field positions and reset values of the frame sync pin block.
  Assumes APB addressing with one aligned 32-bit word per register.
*/
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define FSP_ADDR_W 8
`define FSP_OFS_RX_CLK_CTRL 8'h00
`define FSP_OFS_TX_CLK_CTRL 8'h04
`define FSP_OFS_COMMON_CTRL 8'h08
`define FSP_OFS_COMMON_STATUS 8'h0C
`define FSP_OFS_GPIO_CTRL 8'h10

// ****************************************
// Field positions
// ****************************************
`define FSP_BIT_RX_FS_DIR 0
`define FSP_BIT_TX_FS_DIR 0
`define FSP_BIT_SYNC_MODE 0
`define FSP_BIT_TX_BUF_SEL 1
`define FSP_BIT_OUT_FLAG 2
`define FSP_BIT_NETWORK 3
`define FSP_BIT_IN_FLAG 0
`define FSP_BIT_RX_LEVEL 1
`define FSP_BIT_TX_LEVEL 2
`define FSP_BIT_FS_LEVEL 3
`define FSP_BIT_RX_AUDIO 0
`define FSP_BIT_RX_MODE 1
`define FSP_BIT_RX_GOUT 3
`define FSP_BIT_TX_AUDIO 4
`define FSP_BIT_TX_MODE 5
`define FSP_BIT_TX_GOUT 7

// ****************************************
// Reset values
// ****************************************
`define FSP_RST_BIT 1'b0
`define FSP_RST_MODE 2'h0
`define FSP_RST_OE_N 1'b1

`endif

/* core/fsp_pkg.sv */
/*
  Types of the frame sync pin block.
  Assumes nothing beyond the defines header.
*/
package fsp_pkg;

  // Pin role after function, mode and direction are resolved
  typedef enum logic [2:0] {
    ROLE_GPIO_OFF,
    ROLE_GPIO_IN,
    ROLE_GPIO_OUT,
    ROLE_FS_IN,
    ROLE_FS_OUT,
    ROLE_FLAG_IN,
    ROLE_FLAG_OUT,
    ROLE_BUF_EN
  } fsp_role_t;

  typedef enum logic [1:0] {
    GMODE_OFF = 2'h0,
    GMODE_IN = 2'h1,
    GMODE_OUT = 2'h2
  } fsp_gmode_t;

endpackage

/* core/fsp_sync_if.sv */
/*
  Carrier between the pin block and its input synchroniser.
  Assumes both ends run on pclk.
*/
`timescale 1ns/10ps
`default_nettype none
interface fsp_sync_if;
  logic [2:0] raw;
  logic [2:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface
`default_nettype wire

/* core/fsp_sync.sv */
/*
  Two-stage synchroniser for the pin inputs and the sampled bit clock.
  Assumes raw inputs are asynchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module fsp_sync (
  input wire logic pclk,
  input wire logic presetn,
  fsp_sync_if.sync_side s
);

  logic [2:0] meta;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 3'h0;
      s.sync <= 3'h0;
    end
    else
    begin
      meta <= s.raw;
      s.sync <= meta;
    end
  end

endmodule
`default_nettype wire

/* dv/fsp_codec_model.sv */
/*
  Behavioural model of the external codec on the two frame sync pins.
  Assumes the bench sets the drive flags and that the pins have pull-downs.
*/
`timescale 1ns/10ps
`default_nettype none
module fsp_codec_model (
  input wire logic rx_out,
  input wire logic rx_oe_n,
  input wire logic tx_out,
  input wire logic tx_oe_n,
  output logic rx_pin,
  output logic tx_pin,
  output logic sck
);
  logic rx_drv = 1'b0;
  logic tx_drv = 1'b0;
  logic rx_val = 1'b0;
  logic tx_val = 1'b0;
  logic sck_q = 1'b0;

  // Released pins fall to the pull-down level, never hold the last value
  assign rx_pin = !rx_oe_n ? rx_out : (rx_drv ? rx_val : 1'b0);
  assign tx_pin = !tx_oe_n ? tx_out : (tx_drv ? tx_val : 1'b0);
  assign sck = sck_q;

  // Bit clock runs only inside a frame; fs moves while the clock is low
  task automatic frame(input int nbits, input int fsbits);
    #37;
    for (int i = 0; i < nbits; i++)
    begin
      rx_val = (i < fsbits);
      tx_val = (i < fsbits);
      #160 sck_q = 1'b1;
      #160 sck_q = 1'b0;
    end
    rx_val = 1'b0;
    tx_val = 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/fsp_frame_sync_pins_tb.sv */
/*
  Self-checking bench of the frame sync pin block.
  Assumes the codec model on the pins and a zero-wait APB slave.
*/
`timescale 1ns/10ps
`default_nettype none
module fsp_frame_sync_pins_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_in;
  logic rx_out;
  logic rx_oe_n;
  logic tx_in;
  logic tx_out;
  logic tx_oe_n;
  logic sck;
  logic rx_gen = 1'b0;
  logic tx_gen = 1'b0;
  logic buf_en = 1'b0;
  logic slot = 1'b0;
  logic rx_fs;
  logic tx_fs;
  logic flag;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  int errors = 0;
  int checks = 0;
  int shadow [5] = '{default: 0};

  always #20 pclk = ~pclk;

  fsp_frame_sync_pins u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_sync_pin_in(rx_in), .rx_frame_sync_pin_out(rx_out),
    .rx_frame_sync_pin_oe_n(rx_oe_n), .tx_frame_sync_pin_in(tx_in),
    .tx_frame_sync_pin_out(tx_out), .tx_frame_sync_pin_oe_n(tx_oe_n),
    .sck_pin(sck), .rx_fs_gen(rx_gen), .tx_fs_gen(tx_gen),
    .tx_buf_en(buf_en), .slot_start(slot), .rx_fs(rx_fs), .tx_fs(tx_fs),
    .input_flag_one(flag));

  fsp_codec_model u_codec (.rx_out(rx_out), .rx_oe_n(rx_oe_n),
    .tx_out(tx_out), .tx_oe_n(tx_oe_n), .rx_pin(rx_in), .tx_pin(tx_in),
    .sck(sck));

  // ****************************************
  // Tasks and model
  // ****************************************
  task automatic close_out();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Waits as long as the slave stalls; only the watchdog ends a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a != 8'h0C && a < 8'h14)
      shadow[a[4:2]] = d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk({err, rd}, {1'b0, shadow[a[4:2]]});
  endtask

  task automatic pulse_slot();
    @(posedge pclk);
    slot <= 1'b1;
    @(posedge pclk);
    slot <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Expected {tx_fs, rx_fs} while the codec holds fs high on its pins
  function automatic logic [1:0] fs_model(input logic rdrv,
    input logic tdrv);
    logic rxa;
    logic txa;
    rxa = shadow[4][0] && !shadow[0][0] && rdrv;
    txa = shadow[4][4] && !shadow[1][0] && tdrv;
    fs_model = {txa, shadow[2][0] ? txa : rxa};
  endfunction

  task automatic frame_chk();
    logic [1:0] e;
    e = fs_model(u_codec.rx_drv, u_codec.tx_drv);
    fork
      u_codec.frame(8, 4);
      begin
        repeat (24) @(posedge pclk);
        chk({tx_fs, rx_fs}, e);
      end
    join
    repeat (4) @(posedge pclk);
    chk({tx_fs, rx_fs}, 2'h0);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    v = $urandom(94001);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk({rx_oe_n, tx_oe_n}, 2'h3);
    for (int a = 0; a < 5; a++)
      rdc(8'(a * 4));
    apb(1'b0, 8'h14, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      v = $urandom;
      u_codec.rx_drv = (m != 2);
      u_codec.tx_drv = (m != 2);
      u_codec.rx_val = v[2];
      u_codec.tx_val = v[3];
      wr(8'h10, {24'h0, v[1], 2'(m), 1'b0, v[0], 2'(m), 1'b0});
      rdc(8'h10);
      repeat (4) @(posedge pclk);
      chk({rx_oe_n, tx_oe_n}, {2{m != 2}});
      if (m == 2)
        chk({tx_out, rx_out}, v[1:0]);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd[2:1], m == 1 ? v[3:2] : 2'h0);
      frame_chk();
    end
    $display("test gpio done");
    u_codec.rx_drv = 1'b0;
    u_codec.tx_drv = 1'b1;
    wr(8'h10, 32'h11);
    wr(8'h08, 32'h0);
    frame_chk();
    u_codec.rx_drv = 1'b1;
    frame_chk();
    wr(8'h08, 32'h1);
    frame_chk();
    $display("test fs in done");
    u_codec.rx_drv = 1'b0;
    u_codec.tx_drv = 1'b0;
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    for (int c = 0; c < 2; c++)
    begin
      if (c == 1)
        wr(8'h08, 32'h3);
      for (int i = 0; i < 4; i++)
      begin
        v = $urandom;
        @(posedge pclk);
        rx_gen <= v[0];
        tx_gen <= v[1];
        buf_en <= v[2];
        repeat (2) @(posedge pclk);
        chk({rx_oe_n, rx_out}, {1'b0, c == 1 ? v[2] : v[0]});
        chk({tx_oe_n, tx_out}, {1'b0, v[1]});
      end
    end
    $display("test fs out done");
    u_codec.tx_drv = 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h5);
    rdc(8'h08);
    chk({rx_oe_n, rx_out}, 2'h0);
    frame_chk();
    chk(rx_out, 1'b1);
    wr(8'h08, 32'h9);
    repeat (3) @(posedge pclk);
    chk(rx_out, 1'b1);
    pulse_slot();
    chk({rx_oe_n, rx_out}, 2'h0);
    wr(8'h00, 32'h0);
    u_codec.rx_drv = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      u_codec.rx_val = (i == 1);
      repeat (4) @(posedge pclk);
      chk(rx_oe_n, 1'b1);
      if (i > 0)
        chk(flag, i == 2);
      pulse_slot();
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[0], flag}, {2{i == 1}});
    end
    $display("test flags done");
    close_out();
  end

  // Whole run is well under this span; a hang ends here
  initial
  begin
    #400000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
